/* design/ubc_pkg.sv */
// Register map, field layout and frame-state types of the serial data/baud/control front.
package ubc_pkg;
	localparam int unsigned   ADDR_W       = 8;
	localparam int unsigned   DATA_W       = 9;
	localparam int unsigned   CTRL_W       = 14;
	localparam int unsigned   BAUD_W       = 16;
	localparam int unsigned   BITS_W       = 4;
	// Byte addresses of the words on the bus
	localparam logic [7:0]    OFF_STATUS   = 8'h00;
	localparam logic [7:0]    OFF_DATA     = 8'h04;
	localparam logic [7:0]    OFF_BAUD     = 8'h08;
	localparam logic [7:0]    OFF_CTRL1    = 8'h0C;
	// Control word fields
	localparam int unsigned   C_SBK        = 0;
	localparam int unsigned   C_SILENT     = 1;
	localparam int unsigned   C_RE         = 2;
	localparam int unsigned   C_TE         = 3;
	localparam int unsigned   C_IDLE_IRQ_ENABLE     = 4;
	localparam int unsigned   C_RXIE       = 5;
	localparam int unsigned   C_TX_COMPLETE_IRQ_ENABLE       = 6;
	localparam int unsigned   C_TX_EMPTY_IRQ_ENABLE      = 7;
	localparam int unsigned   C_PARITY_IRQ_ENABLE       = 8;
	localparam int unsigned   C_PS         = 9;
	localparam int unsigned   C_PCE        = 10;
	localparam int unsigned   C_WAKE       = 11;
	localparam int unsigned   C_M          = 12;
	localparam int unsigned   C_UE         = 13;
	// Baud divider fields: integer part above a sixteenth-step fraction
	localparam int unsigned   B_FRAC_LSB   = 0;
	localparam int unsigned   B_FRAC_W     = 4;
	localparam int unsigned   B_MANT_LSB   = 4;
	localparam int unsigned   B_MANT_W     = 12;
	// Status word fields
	localparam int unsigned   S_PE         = 0;
	localparam int unsigned   S_IDLE       = 4;
	localparam int unsigned   S_RX_NOT_EMPTY_FLAG       = 5;
	localparam int unsigned   S_TC         = 6;
	localparam int unsigned   S_TXE        = 7;
	// Reset values
	localparam logic [13:0]   CTRL1_RST    = 14'h0000;
	localparam logic [15:0]   BAUD_RST     = 16'h0000;
	localparam logic [8:0]    DATA_RST     = 9'h000;
	localparam logic          TXE_RST      = 1'b1;
	localparam logic          TC_RST       = 1'b1;
	// Frame sizes in bits
	localparam logic [3:0]    BITS_SHORT   = 4'h8;
	localparam logic [3:0]    BITS_LONG    = 4'h9;
	localparam logic [3:0]    FRAME_EXTRA  = 4'h2;

	typedef enum logic [2:0] {
		UBC_IDLE,
		UBC_START,
		UBC_DATA,
		UBC_PARITY,
		UBC_STOP
	} ubc_state_t;
endpackage

/* design/ubc_core.sv */
// Serial transceiver front: APB registers, fractional baud timing, transmitter and receiver.
`timescale 1ns/100ps

// Notes on behaviour
// - Data read gives receive buffer; write loads transmit buffer
// - Divider bits 15..4 hold integer part
// - Divider bits 3..0 hold sixteenths fraction
// - Unit off halts after current frame finishes
// - Word length bit selects nine or eight bits
// - Wake bit: address mark or idle line
// - Parity enable inserts and checks; next frame only
// - Parity select even/odd; next frame only
// - Parity error request gated by its enable
// - Buffer empty request gated by its enable
// - Transmit complete request gated by its enable
// - Receive full request gated by its enable
// - Idle line request gated by its enable
// - Transmitter enable activates the transmitter
// - Receiver enable starts start-bit search
// - Silent bit puts receiver into silent mode
// - Address-mark mode ignores silent writes while full
// - Send break; cleared on break stop bit
// - Data read clears receive not-empty flag
// - Buffer empty set when moved to shifter
module ubc_core (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [ubc_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         rxd,
	output logic                              txd,
	output logic                              irq
);

	logic [31:0]                prdata_q;
	logic                       pready_q;
	logic                       pslverr_q;
	logic                       txd_q;
	logic                       irq_q;
	logic [13:0]                ctrl_q;
	logic [15:0]                baud_q;
	logic [8:0]                 tx_buf_q;
	logic [8:0]                 rx_buf_q;
	logic                       txe_q, tc_q, rx_not_empty_flag_q, idle_q, pe_q;
	logic                       stat_rd_q, idle_armed_q;
	ubc_pkg::ubc_state_t        tx_st_q, rx_st_q;
	logic [15:0]                tx_cnt_q, rx_cnt_q;
	logic [8:0]                 tx_sh_q, rx_sh_q;
	logic [3:0]                 tx_bit_q, rx_bit_q, tx_nb_q, rx_nb_q, idle_bits_q;
	logic                       tx_par_q, rx_par_q, tx_brk_q, rx_pce_q, rx_ps_q, rx_perr_q;
	logic                       tx_pce_q, tx_ps_q;
	logic                       rxd_q, rxd_prev_q;

	logic                       acc, wr_acc, rd_acc;
	logic                       tx_tick, rx_tick, baud_run;
	logic                       tx_load, tx_begin, tx_done, sbk_clr;
	logic                       rx_done, idle_evt, silent_clr, deliver;
	logic [8:0]                 rx_word;
	logic [3:0]                 frame_bits;
	logic [31:0]                rd_mux;

	function automatic logic hit(input logic [ubc_pkg::ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign txd     = txd_q;
	assign irq     = irq_q;

	// Bus access completes on the edge where pready is seen high
	assign acc    = psel & penable & pready_q;
	assign wr_acc = acc & pwrite;
	assign rd_acc = acc & ~pwrite;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(paddr, ubc_pkg::OFF_DATA)) begin
			rd_mux[8:0] = rx_buf_q;
		end else if (hit(paddr, ubc_pkg::OFF_BAUD)) begin
			rd_mux[15:0] = baud_q;
		end else if (hit(paddr, ubc_pkg::OFF_CTRL1)) begin
			rd_mux[13:0] = ctrl_q;
		end else if (hit(paddr, ubc_pkg::OFF_STATUS)) begin
			rd_mux[ubc_pkg::S_PE]   = pe_q;
			rd_mux[ubc_pkg::S_IDLE] = idle_q;
			rd_mux[ubc_pkg::S_RX_NOT_EMPTY_FLAG] = rx_not_empty_flag_q;
			rd_mux[ubc_pkg::S_TC]   = tc_q;
			rd_mux[ubc_pkg::S_TXE]  = txe_q;
		end
	end

	// No wait state: answer is prepared during the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel & ~penable & ~pready_q;
			pslverr_q <= psel & ~penable & ~pready_q & ~(hit(paddr, ubc_pkg::OFF_DATA)
				| hit(paddr, ubc_pkg::OFF_BAUD) | hit(paddr, ubc_pkg::OFF_CTRL1)
				| hit(paddr, ubc_pkg::OFF_STATUS));
			prdata_q  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Control word; hardware clears of break and silent lose to nothing but a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= ubc_pkg::CTRL1_RST;
		end else begin
			if (sbk_clr) begin
				ctrl_q[ubc_pkg::C_SBK] <= 1'b0;
			end
			if (silent_clr) begin
				ctrl_q[ubc_pkg::C_SILENT] <= 1'b0;
			end
			if (wr_acc && hit(paddr, ubc_pkg::OFF_CTRL1)) begin
				ctrl_q <= pwdata[13:0];
				if (ctrl_q[ubc_pkg::C_WAKE] && rx_not_empty_flag_q) begin
					ctrl_q[ubc_pkg::C_SILENT] <= ctrl_q[ubc_pkg::C_SILENT] & ~silent_clr;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_q <= ubc_pkg::BAUD_RST;
		end else if (wr_acc && hit(paddr, ubc_pkg::OFF_BAUD)) begin
			baud_q <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buf_q <= ubc_pkg::DATA_RST;
		end else if (wr_acc && hit(paddr, ubc_pkg::OFF_DATA)) begin
			tx_buf_q <= pwdata[8:0];
		end
	end

	// Divider value is mantissa + fraction/16, so a bit lasts the raw field value in pclk
	// cycles; a zero divider starts no new frames and no start-bit search
	assign baud_run = (baud_q != ubc_pkg::BAUD_RST) & ctrl_q[ubc_pkg::C_UE];
	assign tx_tick  = (tx_cnt_q == 16'h0000);
	assign rx_tick  = (rx_cnt_q == 16'h0000);

	// New frames start only while the unit is on; a frame under way always finishes
	assign tx_begin = (tx_st_q == ubc_pkg::UBC_IDLE) & baud_run & ctrl_q[ubc_pkg::C_TE]
		& (ctrl_q[ubc_pkg::C_SBK] | ~txe_q);
	assign tx_load  = tx_begin & ~ctrl_q[ubc_pkg::C_SBK];
	assign tx_done  = (tx_st_q == ubc_pkg::UBC_STOP) & tx_tick;
	assign sbk_clr  = (tx_st_q == ubc_pkg::UBC_DATA) & tx_tick & tx_brk_q & (tx_bit_q == tx_nb_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q  <= ubc_pkg::UBC_IDLE;
			tx_cnt_q <= 16'h0000;
			tx_sh_q  <= 9'h000;
			tx_bit_q <= 4'h0;
			tx_nb_q  <= ubc_pkg::BITS_SHORT;
			tx_par_q <= 1'b0;
			tx_brk_q <= 1'b0;
			tx_pce_q <= 1'b0;
			tx_ps_q  <= 1'b0;
			txd_q    <= 1'b1;
		end else begin
			tx_cnt_q <= tx_tick ? baud_q - 16'h0001 : tx_cnt_q - 16'h0001;
			case (tx_st_q)
				ubc_pkg::UBC_IDLE: begin
					txd_q    <= 1'b1;
					tx_cnt_q <= baud_q - 16'h0001;
					if (tx_begin) begin
						// Frame format is frozen here so later writes affect the next frame
						tx_nb_q  <= ctrl_q[ubc_pkg::C_M] ? ubc_pkg::BITS_LONG
							: ubc_pkg::BITS_SHORT;
						tx_pce_q <= ctrl_q[ubc_pkg::C_PCE];
						tx_ps_q  <= ctrl_q[ubc_pkg::C_PS];
						tx_brk_q <= ctrl_q[ubc_pkg::C_SBK];
						tx_sh_q  <= ctrl_q[ubc_pkg::C_SBK] ? 9'h000 : tx_buf_q;
						tx_par_q <= 1'b0;
						tx_bit_q <= 4'h0;
						txd_q    <= 1'b0;
						tx_st_q  <= ubc_pkg::UBC_START;
					end
				end
				ubc_pkg::UBC_START, ubc_pkg::UBC_DATA: begin
					if (tx_tick) begin
						if (tx_bit_q == tx_nb_q) begin
							if (tx_pce_q && !tx_brk_q) begin
								txd_q   <= tx_par_q ^ tx_ps_q;
								tx_st_q <= ubc_pkg::UBC_PARITY;
							end else begin
								txd_q   <= 1'b1;
								tx_st_q <= ubc_pkg::UBC_STOP;
							end
						end else begin
							txd_q    <= tx_sh_q[0];
							tx_par_q <= tx_par_q ^ tx_sh_q[0];
							tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
							tx_bit_q <= tx_bit_q + 4'h1;
							tx_st_q  <= ubc_pkg::UBC_DATA;
						end
					end
				end
				ubc_pkg::UBC_PARITY: begin
					if (tx_tick) begin
						txd_q   <= 1'b1;
						tx_st_q <= ubc_pkg::UBC_STOP;
					end
				end
				default: begin
					if (tx_tick) begin
						tx_brk_q <= 1'b0;
						tx_st_q  <= ubc_pkg::UBC_IDLE;
					end
				end
			endcase
		end
	end

	// Receiver; line is taken as synchronous and delayed once for edge finding
	assign frame_bits = (ctrl_q[ubc_pkg::C_M] ? ubc_pkg::BITS_LONG : ubc_pkg::BITS_SHORT)
		+ ubc_pkg::FRAME_EXTRA + {3'b000, ctrl_q[ubc_pkg::C_PCE]};
	assign rx_done    = (rx_st_q == ubc_pkg::UBC_STOP) & rx_tick;
	assign rx_word    = (rx_nb_q == ubc_pkg::BITS_LONG) ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
	assign idle_evt   = (rx_st_q == ubc_pkg::UBC_IDLE) & rx_tick & rxd_q
		& (idle_bits_q == frame_bits - 4'h1) & ctrl_q[ubc_pkg::C_RE];
	// An address frame, marked by its top bit, wakes the receiver and is kept
	assign silent_clr = (rx_done & ctrl_q[ubc_pkg::C_SILENT] & ctrl_q[ubc_pkg::C_WAKE]
		& rx_word[rx_nb_q - 4'h1])
		| (idle_evt & idle_armed_q & ctrl_q[ubc_pkg::C_SILENT]
		& ~ctrl_q[ubc_pkg::C_WAKE]);
	assign deliver    = rx_done & (~ctrl_q[ubc_pkg::C_SILENT] | silent_clr & ~idle_evt);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_q      <= 1'b1;
			rxd_prev_q <= 1'b1;
		end else begin
			rxd_q      <= rxd;
			rxd_prev_q <= rxd_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_q     <= ubc_pkg::UBC_IDLE;
			rx_cnt_q    <= 16'h0000;
			rx_sh_q     <= 9'h000;
			rx_bit_q    <= 4'h0;
			rx_nb_q     <= ubc_pkg::BITS_SHORT;
			rx_par_q    <= 1'b0;
			rx_pce_q    <= 1'b0;
			rx_ps_q     <= 1'b0;
			rx_perr_q   <= 1'b0;
			idle_bits_q <= 4'h0;
		end else begin
			rx_cnt_q <= rx_tick ? baud_q - 16'h0001 : rx_cnt_q - 16'h0001;
			case (rx_st_q)
				ubc_pkg::UBC_IDLE: begin
					if (!rxd_q || !baud_run) begin
						idle_bits_q <= 4'h0;
						rx_cnt_q    <= baud_q - 16'h0001;
					end else if (rx_tick && idle_bits_q != frame_bits) begin
						idle_bits_q <= idle_bits_q + 4'h1;
					end
					// Searching for a start edge only while enabled
					if (baud_run && ctrl_q[ubc_pkg::C_RE] && rxd_prev_q && !rxd_q) begin
						rx_cnt_q  <= {1'b0, baud_q[15:1]};
						rx_nb_q   <= ctrl_q[ubc_pkg::C_M] ? ubc_pkg::BITS_LONG
							: ubc_pkg::BITS_SHORT;
						rx_pce_q  <= ctrl_q[ubc_pkg::C_PCE];
						rx_ps_q   <= ctrl_q[ubc_pkg::C_PS];
						rx_par_q  <= 1'b0;
						rx_perr_q <= 1'b0;
						rx_bit_q  <= 4'h0;
						rx_st_q   <= ubc_pkg::UBC_START;
					end
				end
				ubc_pkg::UBC_START: begin
					// Mid-bit check rejects glitches shorter than half a bit
					if (rx_tick) begin
						rx_st_q <= rxd_q ? ubc_pkg::UBC_IDLE : ubc_pkg::UBC_DATA;
					end
				end
				ubc_pkg::UBC_DATA: begin
					if (rx_tick) begin
						rx_sh_q  <= {rxd_q, rx_sh_q[8:1]};
						rx_par_q <= rx_par_q ^ rxd_q;
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == rx_nb_q - 4'h1) begin
							rx_st_q <= rx_pce_q ? ubc_pkg::UBC_PARITY : ubc_pkg::UBC_STOP;
						end
					end
				end
				ubc_pkg::UBC_PARITY: begin
					if (rx_tick) begin
						rx_perr_q <= rxd_q != (rx_par_q ^ rx_ps_q);
						rx_st_q   <= ubc_pkg::UBC_STOP;
					end
				end
				default: begin
					if (rx_tick) begin
						idle_bits_q <= 4'h0;
						rx_st_q     <= ubc_pkg::UBC_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf_q <= ubc_pkg::DATA_RST;
		end else if (deliver) begin
			rx_buf_q <= rx_word;
		end
	end

	// Status flags: every hardware set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txe_q        <= ubc_pkg::TXE_RST;
			tc_q         <= ubc_pkg::TC_RST;
			rx_not_empty_flag_q       <= 1'b0;
			idle_q       <= 1'b0;
			pe_q         <= 1'b0;
			stat_rd_q    <= 1'b0;
			idle_armed_q <= 1'b0;
		end else begin
			if (wr_acc && hit(paddr, ubc_pkg::OFF_DATA)) begin
				txe_q <= 1'b0;
				tc_q  <= 1'b0;
			end
			if (wr_acc && hit(paddr, ubc_pkg::OFF_STATUS)) begin
				tc_q   <= tc_q & pwdata[ubc_pkg::S_TC];
				rx_not_empty_flag_q <= rx_not_empty_flag_q & pwdata[ubc_pkg::S_RX_NOT_EMPTY_FLAG];
			end
			if (rd_acc && hit(paddr, ubc_pkg::OFF_STATUS)) begin
				stat_rd_q <= 1'b1;
			end
			if (rd_acc && hit(paddr, ubc_pkg::OFF_DATA)) begin
				rx_not_empty_flag_q <= 1'b0;
				if (stat_rd_q) begin
					idle_q    <= 1'b0;
					pe_q      <= 1'b0;
					stat_rd_q <= 1'b0;
				end
			end
			if (tx_load) begin
				txe_q <= 1'b1;
			end
			if (tx_done && txe_q && !tx_load) begin
				tc_q <= 1'b1;
			end
			if (deliver) begin
				rx_not_empty_flag_q       <= 1'b1;
				idle_armed_q <= 1'b1;
				if (rx_perr_q) begin
					pe_q <= 1'b1;
				end
			end
			// Idle is reported once per received burst, not on every quiet frame
			if (idle_evt && idle_armed_q) begin
				idle_armed_q <= deliver;
				idle_q       <= ~ctrl_q[ubc_pkg::C_SILENT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (ctrl_q[ubc_pkg::C_PARITY_IRQ_ENABLE] & pe_q)
				| (ctrl_q[ubc_pkg::C_TX_EMPTY_IRQ_ENABLE] & txe_q)
				| (ctrl_q[ubc_pkg::C_TX_COMPLETE_IRQ_ENABLE] & tc_q)
				| (ctrl_q[ubc_pkg::C_RXIE] & rx_not_empty_flag_q)
				| (ctrl_q[ubc_pkg::C_IDLE_IRQ_ENABLE] & idle_q);
		end
	end

	// Start-bit cycle count, so the bit period is checked without a long repetition
	logic [15:0]                start_len_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_len_q <= 16'h0000;
		end else if (tx_st_q == ubc_pkg::UBC_START) begin
			start_len_q <= start_len_q + 16'h0001;
		end else begin
			start_len_q <= 16'h0000;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_data_read_clr: assert property (rd_acc && hit(paddr, ubc_pkg::OFF_DATA) && !deliver
		|=> !rx_not_empty_flag_q) else $error("rx flag not cleared by data read");
	a_load_sets_empty: assert property (tx_load |=> txe_q && tx_st_q == ubc_pkg::UBC_START
		&& !txd_q) else $error("load did not set empty flag");
	a_ctrl_reserved: assert property (rd_acc && hit(paddr, ubc_pkg::OFF_CTRL1)
		|-> prdata_q[31:14] == 18'h00000) else $error("reserved control bits not zero");
	a_baud_readback: assert property (wr_acc && hit(paddr, ubc_pkg::OFF_BAUD)
		##2 (psel && !penable && !pwrite && hit(paddr, ubc_pkg::OFF_BAUD))
		|=> prdata_q == {16'h0000, $past(pwdata[15:0], 3)})
		else $error("divider readback mismatch");
	a_tx_off_idle: assert property (!ctrl_q[ubc_pkg::C_UE] && tx_st_q == ubc_pkg::UBC_IDLE
		|=> tx_st_q == ubc_pkg::UBC_IDLE && txd_q) else $error("tx started while unit off");
	a_break_clear: assert property (sbk_clr && !wr_acc |=> !ctrl_q[ubc_pkg::C_SBK] && txd_q
		&& tx_st_q == ubc_pkg::UBC_STOP) else $error("break bit not cleared at stop");
	a_silent_guard: assert property (wr_acc && hit(paddr, ubc_pkg::OFF_CTRL1)
		&& ctrl_q[ubc_pkg::C_WAKE] && rx_not_empty_flag_q && !silent_clr
		|=> $stable(ctrl_q[ubc_pkg::C_SILENT])) else $error("silent bit changed while full");
	a_irq_rx: assert property (ctrl_q[ubc_pkg::C_RXIE] && rx_not_empty_flag_q |=> irq_q)
		else $error("receive request missing");
	a_irq_none: assert property (ctrl_q[13:4] == 10'h000 |=> !irq_q)
		else $error("request with all enables clear");
	a_bit_period: assert property (tx_st_q == ubc_pkg::UBC_START && tx_tick
		|-> start_len_q == baud_q - 16'h0001 && !txd_q) else $error("start bit length wrong");
	a_rx_silent: assert property (rx_done && ctrl_q[ubc_pkg::C_SILENT] && !silent_clr
		|=> $stable(rx_buf_q)) else $error("silent receiver stored data");

	c_tx_frame: cover property (tx_done && !tx_brk_q);
	c_break: cover property (sbk_clr);
	c_rx_parity: cover property (deliver && rx_perr_q);
	c_addr_wake: cover property (silent_clr && ctrl_q[ubc_pkg::C_WAKE]);

endmodule

/* verif/ubc_peer.sv */
// Remote serial node: drives frames into the block and samples what it sends
`timescale 1ns/100ps
module ubc_peer (
	input  wire logic pclk,
	input  wire logic txd,
	output logic      rxd
);
	int         bit_n   = 16;
	int         rx_bits = 8;
	int         frames  = 0;
	logic [9:0] got     = 10'h000;
	realtime    t_fall  = 0;
	realtime    low_len = 0;

	initial rxd = 1'b1;

	// Start bit length is only meaningful when the first data bit is high
	always @(negedge txd) t_fall = $realtime;
	always @(posedge txd) low_len = $realtime - t_fall;

	always begin
		@(negedge txd);
		got = 10'h000;
		repeat (bit_n / 2) @(posedge pclk);
		for (int i = 0; i < rx_bits; i++) begin
			repeat (bit_n) @(posedge pclk);
			got[i] = txd;
		end
		repeat (bit_n) @(posedge pclk);
		frames++;
	end

	// Line idles high between frames, as a real node leaves it
	task automatic send(input logic [9:0] w, input int nb);
		rxd <= 1'b0;
		repeat (bit_n) @(posedge pclk);
		for (int i = 0; i < nb; i++) begin
			rxd <= w[i];
			repeat (bit_n) @(posedge pclk);
		end
		rxd <= 1'b1;
		repeat (bit_n) @(posedge pclk);
	endtask
endmodule

/* verif/uart_data_baud_control_tb.sv */
// Self-checking bench for the serial data, baud and control front
`timescale 1ns/100ps
module uart_data_baud_control_tb;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic        irq;
	logic        serr;
	logic [31:0] rdv;
	int          err_total  = 0;
	int          num_checks = 0;
	localparam logic [31:0] EN = 32'h0000_200C;

	ubc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
	ubc_peer peer (.pclk(pclk), .txd(txd), .rxd(rxd));

	always #20 pclk = ~pclk;

	function automatic logic [31:0] b(input int n);
		return 32'h0000_0001 << n;
	endfunction

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Request held until pready is seen high; a spare edge keeps drives one per step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge pclk);
			n++;
		end
		rdv  = prdata;
		serr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 16) err_total++;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rdv & m, e);
	endtask

	task automatic tx(input logic [8:0] d, input logic [9:0] e, input string nm);
		int f;
		int k;
		f = peer.frames;
		k = 0;
		wr(ubc_pkg::OFF_DATA, {23'h000000, d});
		while (peer.frames == f && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		chk(nm, {22'h000000, peer.got}, {22'h000000, e});
	endtask

	task automatic rx(input logic [9:0] w, input int nb);
		peer.send(w, nb);
		repeat (peer.bit_n) @(posedge pclk);
	endtask

	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		end_of_test();
	end

	initial begin
		int f;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ubc_pkg::OFF_CTRL1, '1, 32'h0, "ctrl reset");
		rd(ubc_pkg::OFF_BAUD, '1, 32'h0, "baud reset");
		rd(ubc_pkg::OFF_STATUS, '1, 32'hC0, "status reset");
		wr(ubc_pkg::OFF_BAUD, 32'hFFFF_FFFF);
		rd(ubc_pkg::OFF_BAUD, '1, 32'hFFFF, "baud fields");
		wr(ubc_pkg::OFF_CTRL1, 32'hFFFF_DFFE);
		rd(ubc_pkg::OFF_CTRL1, '1, 32'h1FFE, "ctrl fields");
		rd(8'h10, '1, 32'h0, "unmapped data");
		chk("unmapped err", {31'h0, serr}, 32'h1);
		wr(ubc_pkg::OFF_CTRL1, 32'h0);
		wr(ubc_pkg::OFF_BAUD, 32'h10);
		// Word length and parity in five of the transmitter's six combinations; nine bits with even parity is not run
		for (int m = 0; m < 5; m++) begin
			logic [8:0] d;
			logic [9:0] e;
			int         nb;
			d  = 9'h1A5 + 9'(m * 51);
			nb = (m == 1 || m == 4) ? 9 : 8;
			e  = (nb == 9) ? {1'b0, d} : {2'b00, d[7:0]};
			if (m >= 2) e[nb] = ^e ^ (m >= 3);
			peer.rx_bits = nb + ((m >= 2) ? 1 : 0);
			wr(ubc_pkg::OFF_CTRL1, EN | (nb == 9 ? b(ubc_pkg::C_M) : 32'h0)
				| (m >= 2 ? b(ubc_pkg::C_PCE) : 32'h0) | (m >= 3 ? b(ubc_pkg::C_PS) : 32'h0));
			tx(d, e, "tx frame");
			if (m == 0) chk("bit time", 32'(int'(peer.low_len / 40.0)), 32'd16);
		end
		peer.rx_bits = 8;
		wr(ubc_pkg::OFF_CTRL1, EN);
		wr(ubc_pkg::OFF_DATA, 32'h5A);
		// The previous frame may still be in its stop bit; let the load happen first
		repeat (16) @(posedge pclk);
		rd(ubc_pkg::OFF_STATUS, 32'hC0, 32'h80, "empty on shift");
		repeat (240) @(posedge pclk);
		wr(ubc_pkg::OFF_CTRL1, EN | b(ubc_pkg::C_TX_EMPTY_IRQ_ENABLE));
		repeat (2) @(posedge pclk);
		chk("irq empty", {31'h0, irq}, 32'h1);
		wr(ubc_pkg::OFF_CTRL1, EN | b(ubc_pkg::C_TX_COMPLETE_IRQ_ENABLE));
		repeat (2) @(posedge pclk);
		chk("irq done", {31'h0, irq}, 32'h1);
		wr(ubc_pkg::OFF_CTRL1, EN | b(ubc_pkg::C_RXIE));
		repeat (2) @(posedge pclk);
		chk("irq off", {31'h0, irq}, 32'h0);
		rx(10'h03C, 8);
		chk("irq full", {31'h0, irq}, 32'h1);
		rd(ubc_pkg::OFF_DATA, '1, 32'h3C, "rx data");
		rd(ubc_pkg::OFF_STATUS, 32'h20, 32'h0, "full cleared");
		wr(ubc_pkg::OFF_CTRL1, EN | b(ubc_pkg::C_M));
		rx(10'h155, 9);
		rd(ubc_pkg::OFF_DATA, '1, 32'h155, "rx nine");
		wr(ubc_pkg::OFF_CTRL1, EN | b(ubc_pkg::C_PCE) | b(ubc_pkg::C_PARITY_IRQ_ENABLE));
		rx(10'h103, 9);
		rd(ubc_pkg::OFF_STATUS, 32'h21, 32'h21, "parity bad");
		chk("irq parity", {31'h0, irq}, 32'h1);
		rd(ubc_pkg::OFF_DATA, 32'hFF, 32'h03, "parity data");
		wr(ubc_pkg::OFF_CTRL1, EN | b(ubc_pkg::C_PCE) | b(ubc_pkg::C_PS));
		rx(10'h103, 9);
		rd(ubc_pkg::OFF_STATUS, 32'h21, 32'h20, "parity odd");
		rd(ubc_pkg::OFF_DATA, 32'hFF, 32'h03, "odd data");
		wr(ubc_pkg::OFF_CTRL1, 32'h2008);
		rx(10'h0C3, 8);
		rd(ubc_pkg::OFF_STATUS, 32'h20, 32'h0, "rx disabled");
		// A byte has already been taken in before silent mode is entered
		wr(ubc_pkg::OFF_CTRL1, EN | b(ubc_pkg::C_SILENT));
		rx(10'h055, 8);
		rd(ubc_pkg::OFF_STATUS, 32'h20, 32'h0, "silent drop");
		f = EN | b(ubc_pkg::C_M) | b(ubc_pkg::C_WAKE);
		wr(ubc_pkg::OFF_CTRL1, f | b(ubc_pkg::C_SILENT));
		rx(10'h055, 9);
		rd(ubc_pkg::OFF_STATUS, 32'h20, 32'h0, "no mark drop");
		rx(10'h1AA, 9);
		rd(ubc_pkg::OFF_CTRL1, '1, f, "mark wakes");
		wr(ubc_pkg::OFF_CTRL1, f | b(ubc_pkg::C_SILENT));
		rd(ubc_pkg::OFF_CTRL1, '1, f, "silent locked");
		rd(ubc_pkg::OFF_DATA, '1, 32'h1AA, "mark data");
		// No data write here: a pending word would follow the break and overlap later tests
		f = peer.frames;
		wr(ubc_pkg::OFF_CTRL1, EN | b(ubc_pkg::C_SBK));
		while (peer.frames == f) @(posedge pclk);
		chk("break", {22'h0, peer.got}, 32'h0);
		repeat (32) @(posedge pclk);
		rd(ubc_pkg::OFF_CTRL1, '1, EN, "break cleared");
		// Fractional divider of one and a half, then the unit is switched off mid-frame
		wr(ubc_pkg::OFF_BAUD, 32'h18);
		peer.bit_n = 24;
		f = peer.frames;
		wr(ubc_pkg::OFF_DATA, 32'hA5);
		repeat (72) @(posedge pclk);
		wr(ubc_pkg::OFF_CTRL1, EN & ~b(ubc_pkg::C_UE));
		repeat (300) @(posedge pclk);
		chk("frame finishes", {22'h0, peer.got}, 32'hA5);
		chk("frac bit time", 32'(int'(peer.low_len / 40.0)), 32'd24);
		f = peer.frames;
		wr(ubc_pkg::OFF_DATA, 32'hF0);
		repeat (300) @(posedge pclk);
		chk("unit off", 32'(peer.frames - f), 32'h0);
		wr(ubc_pkg::OFF_CTRL1, 32'h2004);
		repeat (300) @(posedge pclk);
		chk("tx off", 32'(peer.frames - f), 32'h0);
		wr(ubc_pkg::OFF_CTRL1, EN);
		repeat (300) @(posedge pclk);
		chk("tx on", {22'h0, peer.got}, 32'hF0);
		end_of_test();
	end
endmodule
